// ===== hw/wsat_pkg.sv
// Shared constants and types for the replicate-block write and address translation logic.
// Assumes a byte-wide initiator data path and a byte-wide medium write stream.
package wsat_pkg;

	// Operation codes.
	localparam logic [7:0] OP_WRITE_SAME = 8'h41;
	localparam logic [7:0] OP_SEND_DIAG = 8'h1D;
	localparam logic [7:0] OP_RECV_DIAG = 8'h1C;

	// Command block byte positions and flag bits.
	localparam int CDB_OP_BYTE = 0;
	localparam int CDB_FLAG_BYTE = 1;
	localparam int CDB_LBA_BYTE = 2;
	localparam int CDB_COUNT_BYTE = 7;
	localparam int CDB_LEN_BYTE = 3;
	localparam int CDB_REL_BIT = 0;
	localparam int CDB_LB_BIT = 1;
	localparam int CDB_PB_BIT = 2;

	// Diagnostic page codes.
	localparam logic [7:0] PAGE_SUPPORTED = 8'h00;
	localparam logic [7:0] PAGE_XLATE = 8'h40;
	localparam logic [7:0] PAGE_VENDOR_LO = 8'h80;

	// Translation page layout.
	localparam int PG_CODE = 0;
	localparam int PG_LEN = 2;
	localparam int PG_SRC = 4;
	localparam int PG_DST = 5;
	localparam int PG_ADDR = 6;
	localparam int FLAG_RA_BIT = 7;
	localparam int FLAG_AS_BIT = 6;
	localparam int FLAG_AT_BIT = 5;
	localparam logic [15:0] XLATE_PAGE_LEN = 16'h000A;
	localparam logic [15:0] XLATE_PAGE_BYTES = 16'h000E;
	localparam logic [15:0] SUPP_PAGE_LEN = 16'h0002;
	localparam logic [15:0] SUPP_PAGE_BYTES = 16'h0006;

	// Address formats.
	localparam logic [2:0] FMT_LBA = 3'h0;
	localparam logic [2:0] FMT_BFI = 3'h4;
	localparam logic [2:0] FMT_PHYS = 3'h5;

	// Sense answers.
	localparam logic [3:0] SENSE_NONE = 4'h0;
	localparam logic [3:0] SENSE_ILLEGAL = 4'h5;
	localparam logic [7:0] ASC_NONE = 8'h00;
	localparam logic [7:0] ASC_BAD_OPCODE = 8'h20;
	localparam logic [7:0] ASC_LBA_RANGE = 8'h21;
	localparam logic [7:0] ASC_BAD_CDB = 8'h24;
	localparam logic [7:0] ASC_BAD_PARAM = 8'h26;

	// Block and geometry: one logical block per physical sector.
	localparam int BLK_IDX_W = 9;
	localparam logic [15:0] BLOCK_LAST = 16'h01FF;
	localparam int SECT_BITS = 6;
	localparam int HEAD_BITS = 4;
	localparam logic [23:0] ALT_CYL_START = 24'h00_0FF0;

	// Register map and reset values.
	localparam logic [7:0] REG_IRQ_STATUS = 8'h00;
	localparam logic [7:0] REG_IRQ_MASK = 8'h04;
	localparam logic [7:0] REG_CAPACITY = 8'h08;
	localparam logic [7:0] REG_SENSE = 8'h0C;
	localparam logic [7:0] REG_BLOCKS = 8'h10;
	localparam logic [31:0] CAPACITY_RST = 32'h0001_0000;
	localparam logic [1:0] IRQ_MASK_RST = 2'h0;
	localparam int IRQ_W = 2;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_CHECK = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WS_FILL,
		ST_WS_EMIT,
		ST_SD_FILL,
		ST_SD_CHECK,
		ST_RD_EMIT,
		ST_STATUS
	} wsat_state_e;

endpackage

// ===== hw/wsat_xlate.sv
// Combinational address translator between logical block and physical sector formats.
// Assumes a fixed geometry with power-of-two heads and sectors per track.
module wsat_xlate
	import wsat_pkg::*;
(
	// Request.
	input wire logic [2:0] srcFmt,
	input wire logic [2:0] dstFmt,
	input wire logic [63:0] addrIn,
	input wire logic [31:0] capacity,
	// Result.
	output logic [63:0] addrOut,
	output logic reservedArea,
	output logic altSector,
	output logic altTrack
);
	logic [31:0] lba;
	logic [23:0] cyl;
	logic outOfGeom;

	always_comb begin
		outOfGeom = 1'b0;
		if (srcFmt == FMT_PHYS) begin
			lba = {addrIn[61:40], addrIn[32 +: HEAD_BITS], addrIn[SECT_BITS-1:0]};
			outOfGeom = (addrIn[63:62] != 2'h0) || (addrIn[39:32+HEAD_BITS] != 4'h0) ||
				(addrIn[31:SECT_BITS] != 26'h000_0000);
		end else begin
			lba = addrIn[63:32];
		end
		cyl = {2'b00, lba[31:SECT_BITS+HEAD_BITS]};
		if (dstFmt == FMT_PHYS) begin
			addrOut = {cyl, 4'h0, lba[SECT_BITS +: HEAD_BITS], 26'h000_0000, lba[SECT_BITS-1:0]};
		end else begin
			addrOut = {lba, 32'h0000_0000};
		end
		// A block maps onto exactly one sector, so any part reserved means all of it.
		reservedArea = outOfGeom || (lba >= capacity);
		altSector = 1'b0;
		altTrack = (cyl >= ALT_CYL_START);
	end

endmodule

// ===== hw/wsat_write_same_xlate.sv
// Target-side interpreter for the replicate-block write and the address translation page.
// Assumes the bus phase logic delivers whole command blocks and byte streams with handshakes.
// Summary of operation
// - Take one block, write it repeatedly.
// - Logical stamp puts block address in four bytes.
// - Physical stamp puts sector address in eight bytes.
// - Both stamp flags set: illegal request check.
// - Count contiguous blocks; zero means through end.
// - Decode diagnostic page codes per defined ranges; code takes only 00h and 40h, vendor range rejected.
// - Unsupported source format: invalid parameter check.
// - Unsupported destination format: invalid parameter check.
// - Result returned only by later receive command.
// - Returned page carries code, length, formats, flags.
// - Reserved-area flag when any part reserved.
// - Alternate sector zero if unknown; track set.
// - Page length counts bytes after length field.
// - Return every result address of a mapping.
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
module wsat_write_same_xlate (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Command block, byte 0 in the top bits.
	input wire logic cdbValid,
	input wire logic [79:0] cdbData,
	output logic cdbReady,
	// Data from the initiator.
	input wire logic [7:0] hostWrByte,
	input wire logic hostWrValid,
	output logic hostWrReady,
	// Data to the initiator.
	output logic [7:0] hostRdByte,
	output logic hostRdValid,
	output logic hostRdLast,
	input wire logic hostRdReady,
	// Medium write stream.
	output logic [7:0] medByte,
	output logic [31:0] medLba,
	output logic medLast,
	output logic medValid,
	input wire logic medReady,
	// Command completion.
	output logic statusValid,
	output logic statusCheck,
	output logic [3:0] senseKey,
	output logic [7:0] addSense,
	// AXI4-Lite register slave.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Interrupt.
	output logic irq
);
	import wsat_pkg::*;

	wsat_state_e state_q;
	logic [15:0] byteIdx_q;
	logic [15:0] xferLen_q;
	logic [31:0] curLba_q;
	logic [31:0] remaining_q;
	logic stampLb_q;
	logic stampPb_q;
	logic emitDone_q;
	logic [7:0] pendPage_q;
	logic [2:0] resSrc_q;
	logic [2:0] resDst_q;
	logic [2:0] resFlags_q;
	logic [63:0] resAddr_q;
	logic [31:0] blocksWritten_q;
	logic statusCheck_q;
	logic [3:0] senseKey_q;
	logic [7:0] addSense_q;
	logic statusValid_q;
	logic [7:0] medByte_q;
	logic [31:0] medLba_q;
	logic medLast_q;
	logic medValid_q;
	logic [7:0] hostRdByte_q;
	logic hostRdValid_q;
	logic hostRdLast_q;
	logic [7:0] blockMem [2**BLK_IDX_W];
	logic [7:0] pageMem [XLATE_PAGE_BYTES];
	logic awPend_q;
	logic wPend_q;
	logic [7:0] awAddr_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic [IRQ_W-1:0] irqStatus_q;
	logic [IRQ_W-1:0] irqMask_q;
	logic [31:0] capacity_q;

	function automatic logic [7:0] vecByte(input logic [79:0] v, input int n);
		return v[79-8*n -: 8];
	endfunction

	function automatic logic [7:0] addrByte(input logic [63:0] a, input int n);
		return a[63-8*n -: 8];
	endfunction

	function automatic logic fmtOk(input logic [2:0] f);
		return (f == FMT_LBA) || (f == FMT_PHYS);
	endfunction

	function automatic logic regHit(input logic [7:0] a);
		return (a == REG_IRQ_STATUS) || (a == REG_IRQ_MASK) || (a == REG_CAPACITY) ||
			(a == REG_SENSE) || (a == REG_BLOCKS);
	endfunction

	function automatic logic [31:0] strbMerge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Command block fields, most significant byte first.
	logic [7:0] cmdOp;
	logic [7:0] cmdFlags;
	logic [31:0] cmdLba;
	logic [15:0] cmdCount;
	logic [15:0] cmdLen;
	logic [31:0] spaceLeft;

	assign cmdOp = vecByte(cdbData, CDB_OP_BYTE);
	assign cmdFlags = vecByte(cdbData, CDB_FLAG_BYTE);
	assign cmdLba = {vecByte(cdbData, CDB_LBA_BYTE), vecByte(cdbData, CDB_LBA_BYTE + 1),
		vecByte(cdbData, CDB_LBA_BYTE + 2), vecByte(cdbData, CDB_LBA_BYTE + 3)};
	assign cmdCount = {vecByte(cdbData, CDB_COUNT_BYTE), vecByte(cdbData, CDB_COUNT_BYTE + 1)};
	assign cmdLen = {vecByte(cdbData, CDB_LEN_BYTE), vecByte(cdbData, CDB_LEN_BYTE + 1)};
	assign spaceLeft = capacity_q - cmdLba;

	// Stored outbound page fields.
	logic [7:0] pgCode;
	logic [15:0] pgLen;
	logic [2:0] pgSrc;
	logic [2:0] pgDst;
	logic [63:0] pgAddr;

	assign pgCode = pageMem[PG_CODE];
	assign pgLen = {pageMem[PG_LEN], pageMem[PG_LEN+1]};
	assign pgSrc = pageMem[PG_SRC][2:0];
	assign pgDst = pageMem[PG_DST][2:0];
	assign pgAddr = {pageMem[PG_ADDR], pageMem[PG_ADDR+1], pageMem[PG_ADDR+2],
		pageMem[PG_ADDR+3], pageMem[PG_ADDR+4], pageMem[PG_ADDR+5], pageMem[PG_ADDR+6],
		pageMem[PG_ADDR+7]};

	// The translator serves the sector stamp while replicating and the page otherwise.
	logic wsActive;
	logic [2:0] xlSrc;
	logic [2:0] xlDst;
	logic [63:0] xlIn;
	logic [63:0] xlOut;
	logic xlReserved;
	logic xlAltSec;
	logic xlAltTrk;

	assign wsActive = (state_q == ST_WS_EMIT);
	assign xlSrc = wsActive ? FMT_LBA : pgSrc;
	assign xlDst = wsActive ? FMT_PHYS : pgDst;
	assign xlIn = wsActive ? {curLba_q, 32'h0000_0000} : pgAddr;

	wsat_xlate xlate (
		.srcFmt(xlSrc),
		.dstFmt(xlDst),
		.addrIn(xlIn),
		.capacity(capacity_q),
		.addrOut(xlOut),
		.reservedArea(xlReserved),
		.altSector(xlAltSec),
		.altTrack(xlAltTrk)
	);

	// Byte sent to the medium: the held block, optionally stamped.
	logic [7:0] stampByte;

	always_comb begin
		stampByte = blockMem[byteIdx_q[BLK_IDX_W-1:0]];
		if (stampPb_q && (byteIdx_q < 16'h0008)) begin
			stampByte = addrByte(xlOut, int'(byteIdx_q[2:0]));
		end else if (stampLb_q && (byteIdx_q < 16'h0004)) begin
			stampByte = addrByte({curLba_q, 32'h0000_0000}, int'(byteIdx_q[1:0]));
		end
	end

	// Byte of the page returned to the initiator.
	logic [7:0] pageByte;

	always_comb begin
		pageByte = 8'h00;
		if (pendPage_q == PAGE_XLATE) begin
			unique case (byteIdx_q)
				16'h0000: pageByte = PAGE_XLATE;
				16'h0002: pageByte = XLATE_PAGE_LEN[15:8];
				16'h0003: pageByte = XLATE_PAGE_LEN[7:0];
				16'h0004: pageByte = {5'h00, resSrc_q};
				16'h0005: pageByte = {resFlags_q, 2'b00, resDst_q};
				default: begin
					if (byteIdx_q >= 16'(PG_ADDR)) begin
						pageByte = addrByte(resAddr_q, int'(byteIdx_q[2:0] - 3'(PG_ADDR)));
					end
				end
			endcase
		end else begin
			unique case (byteIdx_q)
				16'h0003: pageByte = SUPP_PAGE_LEN[7:0];
				16'h0005: pageByte = PAGE_XLATE;
				default: pageByte = 8'h00;
			endcase
		end
	end

	logic medLoad;
	logic rdLoad;

	assign medLoad = !medValid_q || medReady;
	assign rdLoad = !hostRdValid_q || hostRdReady;
	assign cdbReady = (state_q == ST_IDLE);
	assign hostWrReady = (state_q == ST_WS_FILL) || (state_q == ST_SD_FILL);

	task automatic finish(input logic chk, input logic [3:0] key, input logic [7:0] asc);
		statusCheck_q <= chk;
		senseKey_q <= key;
		addSense_q <= asc;
		state_q <= ST_STATUS;
	endtask

	// Command sequencing and data movement.
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			byteIdx_q <= 16'h0000;
			xferLen_q <= 16'h0000;
			curLba_q <= 32'h0000_0000;
			remaining_q <= 32'h0000_0000;
			stampLb_q <= 1'b0;
			stampPb_q <= 1'b0;
			emitDone_q <= 1'b0;
			pendPage_q <= PAGE_SUPPORTED;
			resSrc_q <= FMT_LBA;
			resDst_q <= FMT_LBA;
			resFlags_q <= 3'h0;
			resAddr_q <= 64'h0000_0000_0000_0000;
			blocksWritten_q <= 32'h0000_0000;
			statusCheck_q <= 1'b0;
			senseKey_q <= SENSE_NONE;
			addSense_q <= ASC_NONE;
			statusValid_q <= 1'b0;
			medByte_q <= 8'h00;
			medLba_q <= 32'h0000_0000;
			medLast_q <= 1'b0;
			medValid_q <= 1'b0;
			hostRdByte_q <= 8'h00;
			hostRdValid_q <= 1'b0;
			hostRdLast_q <= 1'b0;
		end else begin
			statusValid_q <= (state_q == ST_STATUS);
			unique case (state_q)
				ST_IDLE: begin
					byteIdx_q <= 16'h0000;
					emitDone_q <= 1'b0;
					if (cdbValid) begin
						unique case (cmdOp)
							OP_WRITE_SAME: begin
								stampLb_q <= cmdFlags[CDB_LB_BIT];
								stampPb_q <= cmdFlags[CDB_PB_BIT];
								curLba_q <= cmdLba;
								if (cmdFlags[CDB_LB_BIT] && cmdFlags[CDB_PB_BIT]) begin
									finish(1'b1, SENSE_ILLEGAL, ASC_BAD_CDB);
								end else if (cmdFlags[CDB_REL_BIT]) begin
									finish(1'b1, SENSE_ILLEGAL, ASC_BAD_CDB);
								end else if ((cmdLba >= capacity_q) ||
										({16'h0000, cmdCount} > spaceLeft)) begin
									finish(1'b1, SENSE_ILLEGAL, ASC_LBA_RANGE);
								end else begin
									remaining_q <= (cmdCount == 16'h0000) ? spaceLeft :
										{16'h0000, cmdCount};
									state_q <= ST_WS_FILL;
								end
							end
							OP_SEND_DIAG: begin
								xferLen_q <= cmdLen;
								if (cmdLen == 16'h0000) begin
									finish(1'b0, SENSE_NONE, ASC_NONE);
								end else begin
									state_q <= ST_SD_FILL;
								end
							end
							OP_RECV_DIAG: begin
								if (pendPage_q == PAGE_XLATE) begin
									xferLen_q <= (cmdLen < XLATE_PAGE_BYTES) ? cmdLen :
										XLATE_PAGE_BYTES;
								end else begin
									xferLen_q <= (cmdLen < SUPP_PAGE_BYTES) ? cmdLen :
										SUPP_PAGE_BYTES;
								end
								if (cmdLen == 16'h0000) begin
									finish(1'b0, SENSE_NONE, ASC_NONE);
								end else begin
									state_q <= ST_RD_EMIT;
								end
							end
							default: finish(1'b1, SENSE_ILLEGAL, ASC_BAD_OPCODE);
						endcase
					end
				end
				ST_WS_FILL: begin
					if (hostWrValid) begin
						if (byteIdx_q == BLOCK_LAST) begin
							byteIdx_q <= 16'h0000;
							state_q <= ST_WS_EMIT;
						end else begin
							byteIdx_q <= byteIdx_q + 16'h0001;
						end
					end
				end
				ST_WS_EMIT: begin
					if (medLoad) begin
						if (!emitDone_q) begin
							medValid_q <= 1'b1;
							medByte_q <= stampByte;
							medLba_q <= curLba_q;
							medLast_q <= (byteIdx_q == BLOCK_LAST);
							if (byteIdx_q == BLOCK_LAST) begin
								byteIdx_q <= 16'h0000;
								curLba_q <= curLba_q + 32'h0000_0001;
								remaining_q <= remaining_q - 32'h0000_0001;
								blocksWritten_q <= blocksWritten_q + 32'h0000_0001;
								emitDone_q <= (remaining_q == 32'h0000_0001);
							end else begin
								byteIdx_q <= byteIdx_q + 16'h0001;
							end
						end else begin
							medValid_q <= 1'b0;
							finish(1'b0, SENSE_NONE, ASC_NONE);
						end
					end
				end
				ST_SD_FILL: begin
					if (hostWrValid) begin
						byteIdx_q <= byteIdx_q + 16'h0001;
						if (byteIdx_q == xferLen_q - 16'h0001) begin
							state_q <= ST_SD_CHECK;
						end
					end
				end
				ST_SD_CHECK: begin
					if (pgCode == PAGE_SUPPORTED) begin
						pendPage_q <= PAGE_SUPPORTED;
						finish(1'b0, SENSE_NONE, ASC_NONE);
					end else if (pgCode != PAGE_XLATE || xferLen_q < XLATE_PAGE_BYTES ||
							pgLen != XLATE_PAGE_LEN) begin
						finish(1'b1, SENSE_ILLEGAL, ASC_BAD_PARAM);
					end else if (!fmtOk(pgSrc)) begin
						finish(1'b1, SENSE_ILLEGAL, ASC_BAD_PARAM);
					end else if (!fmtOk(pgDst)) begin
						finish(1'b1, SENSE_ILLEGAL, ASC_BAD_PARAM);
					end else begin
						pendPage_q <= PAGE_XLATE;
						resSrc_q <= pgSrc;
						resDst_q <= pgDst;
						resAddr_q <= xlOut;
						resFlags_q <= {xlReserved, xlAltSec, xlAltTrk};
						finish(1'b0, SENSE_NONE, ASC_NONE);
					end
				end
				ST_RD_EMIT: begin
					if (rdLoad) begin
						if (!emitDone_q) begin
							hostRdValid_q <= 1'b1;
							hostRdByte_q <= pageByte;
							hostRdLast_q <= (byteIdx_q == xferLen_q - 16'h0001);
							byteIdx_q <= byteIdx_q + 16'h0001;
							emitDone_q <= (byteIdx_q == xferLen_q - 16'h0001);
						end else begin
							hostRdValid_q <= 1'b0;
							hostRdLast_q <= 1'b0;
							finish(1'b0, SENSE_NONE, ASC_NONE);
						end
					end
				end
				ST_STATUS: state_q <= ST_IDLE;
			endcase
		end
	end

	// Block and page buffers.
	always_ff @(posedge clk) begin
		if (state_q == ST_WS_FILL && hostWrValid) begin
			blockMem[byteIdx_q[BLK_IDX_W-1:0]] <= hostWrByte;
		end
		if (state_q == ST_SD_FILL && hostWrValid && byteIdx_q < XLATE_PAGE_BYTES) begin
			pageMem[byteIdx_q[3:0]] <= hostWrByte;
		end
	end

	// Register slave.
	logic doWrite;
	logic [31:0] readMux;

	assign doWrite = awPend_q && wPend_q && !bvalid_q;

	always_comb begin
		unique case (s_axi_araddr)
			REG_IRQ_STATUS: readMux = {30'h0000_0000, irqStatus_q};
			REG_IRQ_MASK: readMux = {30'h0000_0000, irqMask_q};
			REG_CAPACITY: readMux = capacity_q;
			REG_SENSE: readMux = {19'h0_0000, statusCheck_q, senseKey_q, addSense_q};
			REG_BLOCKS: readMux = blocksWritten_q;
			default: readMux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			awPend_q <= 1'b0;
			wPend_q <= 1'b0;
			awAddr_q <= 8'h00;
			wData_q <= 32'h0000_0000;
			wStrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
			irqMask_q <= IRQ_MASK_RST;
			capacity_q <= CAPACITY_RST;
		end else begin
			if (s_axi_awvalid && !awPend_q) begin
				awPend_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !wPend_q) begin
				wPend_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (doWrite) begin
				awPend_q <= 1'b0;
				wPend_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= regHit(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
				if (awAddr_q == REG_IRQ_MASK && wStrb_q[0]) begin
					irqMask_q <= wData_q[IRQ_W-1:0];
				end
				if (awAddr_q == REG_CAPACITY) begin
					capacity_q <= strbMerge(capacity_q, wData_q, wStrb_q);
				end
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
			if (s_axi_arvalid && !rvalid_q) begin
				rvalid_q <= 1'b1;
				rdata_q <= readMux;
				rresp_q <= regHit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// Sticky completion events; a new event wins over a clear in the same cycle.
	logic [IRQ_W-1:0] irqSet;
	logic [IRQ_W-1:0] irqClr;

	assign irqSet = {statusValid_q && statusCheck_q, statusValid_q};
	assign irqClr = (doWrite && awAddr_q == REG_IRQ_STATUS && wStrb_q[0]) ?
		wData_q[IRQ_W-1:0] : 2'h0;

	always_ff @(posedge clk) begin
		if (rst) begin
			irqStatus_q <= 2'h0;
		end else begin
			irqStatus_q <= (irqStatus_q & ~irqClr) | irqSet;
		end
	end

	assign irq = |(irqStatus_q & irqMask_q);
	assign s_axi_awready = !awPend_q;
	assign s_axi_wready = !wPend_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign statusValid = statusValid_q;
	assign statusCheck = statusCheck_q;
	assign senseKey = senseKey_q;
	assign addSense = addSense_q;
	assign medByte = medByte_q;
	assign medLba = medLba_q;
	assign medLast = medLast_q;
	assign medValid = medValid_q;
	assign hostRdByte = hostRdByte_q;
	assign hostRdValid = hostRdValid_q;
	assign hostRdLast = hostRdLast_q;

endmodule

// ===== tb/wsat_chk.sv
// Port assertions for the replicate write and translation logic.
// Assumes a bind to the top module.
module wsat_chk (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Command and completion.
	input wire logic cdbValid,
	input wire logic [79:0] cdbData,
	input wire logic cdbReady,
	input wire logic statusValid,
	input wire logic statusCheck,
	input wire logic [3:0] senseKey,
	// Data streams.
	input wire logic hostWrReady,
	input wire logic [7:0] hostRdByte,
	input wire logic hostRdValid,
	input wire logic hostRdLast,
	input wire logic hostRdReady,
	input wire logic [7:0] medByte,
	input wire logic [31:0] medLba,
	input wire logic medLast,
	input wire logic medValid,
	input wire logic medReady
);
	timeunit 1ns;
	timeprecision 1ns;
	import wsat_pkg::*;
	logic [8:0] medCnt_q;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	always_ff @(posedge clk) begin
		if (rst) medCnt_q <= 9'h000;
		else if (medValid && medReady) medCnt_q <= medCnt_q + 9'h001;
	end
	sequence wsBoth;
		cdbValid && cdbReady && cdbData[79:72] == OP_WRITE_SAME && cdbData[66] && cdbData[65];
	endsequence
	sequence refused;
		##2 statusValid && statusCheck && senseKey == SENSE_ILLEGAL && !hostWrReady;
	endsequence
	sequence medStep;
		medValid && medReady ##1 medValid;
	endsequence
	stamp_clash_a: assert property (wsBoth |-> refused)
		else $error("stamp clash accepted");
	med_hold_a: assert property (medValid && !medReady |=>
		medValid && $stable({medByte, medLba})) else $error("medium byte moved");
	block_len_a: assert property (medValid |-> medLast == (medCnt_q == 9'h1FF))
		else $error("block end misplaced");
	lba_step_a: assert property (medStep |->
		medLba == $past(medLba) + {31'h0000_0000, $past(medLast)}) else $error("block address");
	rd_hold_a: assert property (hostRdValid && !hostRdReady |=>
		hostRdValid && $stable({hostRdByte, hostRdLast})) else $error("read byte moved");
	rd_end_a: assert property (hostRdValid && hostRdReady && hostRdLast |=>
		!hostRdValid ##1 statusValid) else $error("read end without status");
	idle_after_a: assert property (statusValid |-> cdbReady ##1 !statusValid)
		else $error("not idle after status");
	busy_cmd_a: assert property (hostWrReady || medValid || hostRdValid |-> !cdbReady)
		else $error("command taken while busy");
endmodule

// ===== tb/wsat_host_model.sv
// Initiator model: sends outbound bytes, paces inbound ones.
// Assumes the bench sets page and pacing before each command.
module wsat_host_model (
	// Clock, reset and pacing.
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	// Outbound page, byte 0 on top.
	input wire logic [111:0] page,
	// Data to and from the target.
	output logic [7:0] hostWrByte,
	output logic hostWrValid,
	input wire logic hostWrReady,
	output logic hostRdReady
);
	timeunit 1ns;
	timeprecision 1ns;
	int idx;
	function automatic logic [7:0] nb(input int i);
		return i < 14 ? page[111 - 8 * i -: 8] : i[7:0];
	endfunction
	always_ff @(posedge clk) begin
		hostRdReady <= !rst && (slow ? !hostRdReady : 1'b1);
		if (rst || !hostWrReady) begin
			idx <= 0;
			hostWrValid <= 1'b0;
			hostWrByte <= rst ? 8'h00 : ~hostWrByte;
		end else if (hostWrValid) begin
			idx <= idx + 1;
			hostWrValid <= !slow;
			hostWrByte <= slow ? ~hostWrByte : nb(idx + 1);
		end else begin
			hostWrValid <= 1'b1;
			hostWrByte <= nb(idx);
		end
	end
endmodule

// ===== tb/test_write_same_and_address_translate.sv
// Bench for the replicate write and translation logic.
// Assumes the initiator model and the bound checker.
module test_write_same_and_address_translate;
	timeunit 1ns;
	timeprecision 1ns;
	import wsat_pkg::*;
	typedef struct {
		logic [79:0] c;
		logic [111:0] p;
		logic [12:0] e;
		logic [111:0] r;
		int n;
	} wsat_row_s;
	localparam logic [111:0] XPG = 112'h4000_000A_0500_000F_F001_0000_0002;
	wsat_row_s rows[12] = '{
		'{80'h1200_0000_0000_0000_0000, '0, 13'h1520, '0, 0},
		'{80'h4106_0000_0000_0000_0100, '0, 13'h1524, '0, 0},
		'{80'h4101_0000_0000_0000_0100, '0, 13'h1524, '0, 0},
		'{80'h4100_0000_0403_0000_0100, '0, 13'h1521, '0, 0},
		'{80'h1D00_0000_0000_0000_0000, '0, 13'h0000, '0, 0},
		'{80'h1D00_0000_0E00_0000_0000, 112'h4000_000A_0305_0000_1234_0000_0000, 13'h1526, '0, 0},
		'{80'h1D00_0000_0E00_0000_0000, 112'h4000_000A_0004_0000_1234_0000_0000, 13'h1526, '0, 0},
		'{80'h1D00_0000_0E00_0000_0000, 112'h8000_000A_0005_0000_1234_0000_0000, 13'h1526, '0, 0},
		'{80'h1D00_0000_0E00_0000_0000, XPG, 13'h0000, '0, 0},
		'{80'h1C00_0000_0E00_0000_0000, '0, 13'h0000, 112'h4000_000A_05A0_003F_C042_0000_0000, 14},
		'{80'h1D00_0000_0400_0000_0000, '0, 13'h0000, '0, 0},
		'{80'h1C00_0000_0600_0000_0000, '0, 13'h0000, 112'h0000_0002_0040_0000_0000_0000_0000, 6}
	};
	logic [40:0] irqSteps[4] = '{{1'b1, REG_IRQ_MASK, 32'h0000_0003},
		{1'b0, REG_IRQ_MASK, 32'h0000_0000}, {1'b1, REG_IRQ_MASK, 32'h0000_0003},
		{1'b0, REG_IRQ_STATUS, 32'h0000_0003}};
	logic clk = 1'b0, rst = 1'b1, cdbValid = 1'b0, medReady = 1'b1, slow = 1'b0, stall = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [79:0] cdbData = '0;
	logic [111:0] page = '0;
	logic cdbReady, hostWrValid, hostWrReady, hostRdValid, hostRdLast, hostRdReady, medLast;
	logic medValid, statusValid, statusCheck, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, irq;
	logic [7:0] hostWrByte, hostRdByte, medByte, addSense;
	logic [31:0] medLba, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [3:0] senseKey;
	int badCount = 0, samplesChecked = 0, cyc = 0, mk = 0, nMed = 0, mode = 0;
	logic [7:0] rq[$];
	wsat_write_same_xlate i_wsat_write_same_xlate (.*);
	wsat_host_model i_wsat_host_model (.*);
	initial forever #50 clk = ~clk;
	task automatic chk(input logic [127:0] seen, input logic [127:0] want);
		samplesChecked++;
		if (seen !== want) begin
			badCount++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
		end
	endtask
	task automatic reportAndStop;
		if (badCount == 0 && samplesChecked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	function automatic logic [7:0] expb(input logic [31:0] l, input int k);
		logic [63:0] ph;
		ph = {2'h0, l[31:10], 4'h0, l[9:6], 26'h000_0000, l[5:0]};
		if (mode == 1 && k < 4) return l[31 - 8 * k -: 8];
		if (mode == 2 && k < 8) return ph[63 - 8 * k -: 8];
		return k < 14 ? page[111 - 8 * k -: 8] : k[7:0];
	endfunction
	task automatic cmd(input logic [79:0] c);
		@(posedge clk);
		cdbData <= c;
		cdbValid <= 1'b1;
		do @(posedge clk); while (cdbReady !== 1'b1);
		cdbValid <= 1'b0;
		do @(posedge clk); while (statusValid !== 1'b1);
	endtask
	task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic [1:0] resp);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_bready <= wr;
		s_axi_arvalid <= !wr;
		s_axi_rready <= !wr;
		forever begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (wr ? s_axi_bvalid : s_axi_rvalid) break;
		end
		r = s_axi_rdata;
		resp = wr ? s_axi_bresp : s_axi_rresp;
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
	endtask
	always @(posedge clk) begin
		cyc++;
		medReady <= stall ? !medReady : 1'b1;
		if (medValid && medReady) begin
			chk(medByte, expb(medLba, mk));
			mk = (mk + 1) % 512;
			nMed++;
		end
		if (hostRdValid && hostRdReady) rq.push_back(hostRdByte);
		if (cyc == 30000) begin
			badCount++;
			reportAndStop();
		end
	end
	initial begin
		logic [31:0] r;
		logic [1:0] e;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		chk({cdbReady, hostWrReady, medValid, hostRdValid, statusValid, statusCheck, irq}, 7'h40);
		axi(1'b0, REG_CAPACITY, '0, r, e);
		chk({e, r}, {RESP_OKAY, CAPACITY_RST});
		axi(1'b1, REG_CAPACITY, 32'h0000_0403, r, e);
		axi(1'b0, 8'h40, '0, r, e);
		chk({e, r}, {RESP_SLVERR, 32'h0000_0000});
		slow <= 1'b1;
		foreach (rows[i]) begin
			page <= rows[i].p;
			rq.delete();
			cmd(rows[i].c);
			chk({statusCheck, senseKey, addSense}, rows[i].e);
			chk(rq.size(), rows[i].n);
			foreach (rq[k]) chk(rq[k], rows[i].r[111 - 8 * k -: 8]);
		end
		for (int m = 1; m < 3; m++) begin
			mode = m;
			page <= XPG;
			slow <= m == 1;
			stall <= m == 2;
			nMed = 0;
			cmd({OP_WRITE_SAME, 5'h00, m[1:0], 1'b0, 32'h0000_0401, 32'h0000_0000});
			chk({statusCheck, nMed}, {1'b0, 32'h0000_0400});
		end
		stall <= 1'b0;
		axi(1'b0, REG_BLOCKS, '0, r, e);
		chk(r, 32'h0000_0004);
		foreach (irqSteps[j]) begin
			axi(1'b1, irqSteps[j][39:32], irqSteps[j][31:0], r, e);
			chk(irq, irqSteps[j][40]);
		end
		reportAndStop();
	end
endmodule
bind wsat_write_same_xlate wsat_chk i_wsat_chk (.*);
